// file: hdl/lop_ctl.sv
// Purpose: Serial control words, RF gate, LO port and monitor decode
// Assumes: Serial pins and gate pins are asynchronous to clk
// Notes: Same words are visible and writable over AHB-Lite
//
// Overview of operation
// R1: RF output is on only while the gate pin is high and word 5 bit 6 is set.
// R2: Direction low, external bit 1, driver bit 0 makes the port an LO input.
// R3: Direction low with external and driver bits 0 leaves the driver off.
// R4: Direction high or driver 1 with external 0 drives 1x or 2x by divider bit.
// R5: Divide value is the integer plus fraction over modulus.
// R6: A sigma-delta modulator spreads the fraction over time.
// R7: A three-bit field in word 4 picks the monitor pin source.
// R8: Each rising serial clock shifts one bit into a 24-bit register.
// R9: A rising latch strobe copies the shift register to the word it selects.
// R10: The host loads words from 7 down to 0 first, then in any order.
// R11: The host turns the LO output off whenever it turns RF off.
// R12: Any other pin and bit mix leaves the driver off and no external route.
//
// The AHB-Lite slave port and the address map were decided locally.
module lop_ctl import lop_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Serial load pins
  input wire logic serial_clock_pin,
  input wire logic serial_data_pin,
  input wire logic latch_load_strobe,
  // Control pins
  input wire logic rf_out_gate_pin,
  input wire logic lo_direction_pin,
  input wire logic pll_source_clock_pin,
  // Monitor sources
  input wire logic lock_detect,
  input wire logic temp_flag,
  // Outputs
  output logic modulator_output,
  output lop_lo_cfg_t lo_port_pair,
  output logic monitor_output_pin,
  output logic [INT_W:0] divide_ratio
);

  logic [NUM_PINS-1:0] s1;
  logic [NUM_PINS-1:0] s2;
  logic [NUM_PINS-1:0] s3;
  logic [NUM_PINS-1:0] lvl;
  logic [NUM_PINS-1:0] lvl_d;
  logic [WORD_W-1:0] shift;
  logic [WORD_W-1:0] ctl_word [NUM_WORDS];
  logic [1:0] ref_div;
  logic wr_pend;
  logic [2:0] wr_idx;
  logic sdm_carry;
  logic [INT_W:0] sdm_ratio;
  logic sck_rise;
  logic latch_rise;
  logic ref_rise;
  lop_lo_cfg_t next_lo;
  lop_mon_sel_t mon_sel;

  // Pick one bit of the LO control word
  function automatic logic lo_bit(input logic [WORD_W-1:0] w,
                                  input int pos);
    return w[pos];
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // A level moves only once the second and third stages agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      lvl <= '0;
      lvl_d <= '0;
    end else begin
      s1 <= {pll_source_clock_pin, lo_direction_pin, rf_out_gate_pin,
             latch_load_strobe, serial_data_pin, serial_clock_pin};
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < NUM_PINS; i++) begin
        if (s2[i] == s3[i]) begin
          lvl[i] <= s3[i];
        end
      end
      lvl_d <= lvl;
    end
  end

  assign sck_rise = lvl[PIN_SCK] & ~lvl_d[PIN_SCK];
  assign latch_rise = lvl[PIN_LATCH] & ~lvl_d[PIN_LATCH];
  assign ref_rise = lvl[PIN_REF] & ~lvl_d[PIN_REF];

  // ---------------------------------------------------------------
  // Serial shift register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shift <= WORD_RST;
    end else if (sck_rise) begin
      shift <= {shift[WORD_W-2:0], lvl[PIN_SDI]}; // R8
    end
  end

  // ---------------------------------------------------------------
  // Control words; a serial latch wins over a bus write
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_WORDS; i++) begin
        ctl_word[i] <= WORD_RST;
      end
    end else if (latch_rise) begin
      ctl_word[shift[SEL_LSB +: SEL_W]] <= shift; // R9
    end else if (wr_pend) begin
      ctl_word[wr_idx] <= hwdata[WORD_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      wr_pend <= 1'b0;
      wr_idx <= 3'h0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= 1'b0;
      if (hsel && hready && htrans == HTRANS_NONSEQ) begin
        // Word registers live below the status word
        wr_pend <= hwrite && haddr[7:0] < ADDR_STATUS;
        wr_idx <= haddr[4:2];
        hrdata <= 32'h0000_0000;
        if (!hwrite) begin
          if (haddr[7:0] < ADDR_STATUS) begin
            hrdata <= {8'h00, ctl_word[haddr[4:2]]};
          end else if (haddr[7:0] == ADDR_STATUS) begin
            hrdata <= {26'h000_0000, lvl[PIN_DIR], lvl[PIN_GATE],
                       lo_port_pair.ext, lo_port_pair.dbl,
                       lo_port_pair.drv, modulator_output};
          end else if (haddr[7:0] == ADDR_RATIO) begin
            hrdata <= 32'(divide_ratio);
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // LO port decode
  // ---------------------------------------------------------------
  always_comb begin
    next_lo = '{drv: 1'b0, dbl: 1'b0, ext: 1'b0};
    if (lo_bit(ctl_word[IDX_LO], LO_EXT_POS)) begin
      // Divider bit has no effect on the input path
      next_lo.ext = !lvl[PIN_DIR]
                    && !lo_bit(ctl_word[IDX_LO], LO_DRV_POS); // R2 R12
    end else if (lvl[PIN_DIR] || lo_bit(ctl_word[IDX_LO], LO_DRV_POS)) begin
      next_lo.drv = 1'b1; // R4
      next_lo.dbl = lo_bit(ctl_word[IDX_LO], LO_DIV_POS); // R4
    end
    // Remaining case keeps everything off R3
  end

  assign mon_sel = lop_mon_sel_t'(ctl_word[IDX_MONITOR][MON_LSB +: 3]);

  // ---------------------------------------------------------------
  // Output flops
  // ---------------------------------------------------------------
  // LO state follows the registers and direction pin, not the gate; software must also clear it
  // whenever RF is gated off R11
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      modulator_output <= 1'b0;
      lo_port_pair <= '{drv: 1'b0, dbl: 1'b0, ext: 1'b0};
    end else begin
      modulator_output <= lvl[PIN_GATE]
                          & lo_bit(ctl_word[IDX_LO], RF_EN_POS); // R1
      lo_port_pair <= next_lo;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ref_div <= 2'h0;
    end else if (ref_rise) begin
      ref_div <= ref_div + 2'h1;
    end
  end

  // Reference is sampled, so it must stay well under half of clk
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      monitor_output_pin <= 1'b0;
    end else begin
      unique case (mon_sel) // R7
        MON_LOW: monitor_output_pin <= 1'b0;
        MON_LOCK: monitor_output_pin <= lock_detect;
        MON_REF: monitor_output_pin <= lvl[PIN_REF];
        MON_REF_DIV2: monitor_output_pin <= ref_div[0];
        MON_REF_DIV4: monitor_output_pin <= ref_div[1];
        MON_TEMP: monitor_output_pin <= temp_flag;
        MON_CARRY: monitor_output_pin <= sdm_carry;
        MON_HIGH: monitor_output_pin <= 1'b1;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Divide value
  // ---------------------------------------------------------------
  lop_sdm #(
    .IW(INT_W),
    .FW(FRAC_W)
  ) u_sdm (
    .clk(clk),
    .nrst(nrst),
    .step(ref_rise),
    .int_val(ctl_word[IDX_INT][INT_LSB +: INT_W]),
    .frac(ctl_word[IDX_FRAC][FRAC_LSB +: FRAC_W]),
    .modulus(ctl_word[IDX_MODULUS][FRAC_LSB +: FRAC_W]),
    .ratio(sdm_ratio),
    .carry(sdm_carry)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      divide_ratio <= '0;
    end else begin
      divide_ratio <= sdm_ratio; // R5
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  rf_gate_a: assert property (@(posedge clk) disable iff (!nrst) // R1
    !lvl[PIN_GATE] ##1 !lvl[PIN_GATE] |-> !modulator_output)
    else $error("RF enabled with gate pin low");

  lo_input_a: assert property (@(posedge clk) disable iff (!nrst) // R2
    (!lvl[PIN_DIR] && ctl_word[IDX_LO][LO_EXT_POS]
      && !ctl_word[IDX_LO][LO_DRV_POS]) |=> lo_port_pair.ext
      && !lo_port_pair.drv)
    else $error("LO input mode not taken");

  lo_off_a: assert property (@(posedge clk) disable iff (!nrst) // R3
    (!lvl[PIN_DIR] && !ctl_word[IDX_LO][LO_EXT_POS]
      && !ctl_word[IDX_LO][LO_DRV_POS]) |=> lo_port_pair == '0)
    else $error("LO driver on in disabled mode");

  lo_drive_a: assert property (@(posedge clk) disable iff (!nrst) // R4
    (!ctl_word[IDX_LO][LO_EXT_POS]
      && (lvl[PIN_DIR] || ctl_word[IDX_LO][LO_DRV_POS]))
      |=> lo_port_pair.drv
      && lo_port_pair.dbl == $past(ctl_word[IDX_LO][LO_DIV_POS]))
    else $error("LO drive or multiple wrong");

  lo_illegal_a: assert property (@(posedge clk) disable iff (!nrst) // R12
    (ctl_word[IDX_LO][LO_EXT_POS]
      && (lvl[PIN_DIR] || ctl_word[IDX_LO][LO_DRV_POS]))
      |=> !lo_port_pair.drv && !lo_port_pair.ext)
    else $error("Undefined LO mix not kept off");

  mon_low_a: assert property (@(posedge clk) disable iff (!nrst) // R7
    (mon_sel == MON_LOW) [*2] |-> !monitor_output_pin)
    else $error("Monitor not low for source zero");

  shift_in_a: assert property (@(posedge clk) disable iff (!nrst) // R8
    sck_rise |=> shift[0] == $past(lvl[PIN_SDI])
      && shift[WORD_W-1:1] == $past(shift[WORD_W-2:0]))
    else $error("Serial bit not shifted in");

  latch_copy_a: assert property (@(posedge clk) disable iff (!nrst) // R9
    latch_rise |=> ctl_word[$past(shift[SEL_LSB +: SEL_W])] == $past(shift))
    else $error("Latch did not load selected word");

endmodule

// file: hdl/lop_pkg.sv
// Purpose: Shared constants and types for the LO port and RF enable control
// Assumes: 250 MHz system clock, 32-bit AHB-Lite register bus
// Notes: Control words are 24 bits, eight of them, selected by bits [2:0]
package lop_pkg;

  // ---------------------------------------------------------------
  // Control word layout
  // ---------------------------------------------------------------
  localparam int WORD_W = 24;
  localparam int NUM_WORDS = 8;
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 3;
  localparam logic [23:0] WORD_RST = 24'h00_0000;

  localparam int IDX_INT = 0;
  localparam int IDX_FRAC = 1;
  localparam int IDX_MODULUS = 2;
  localparam int IDX_MONITOR = 4;
  localparam int IDX_LO = 5;

  localparam int INT_LSB = 3;
  localparam int INT_W = 16;
  localparam int FRAC_LSB = 3;
  localparam int FRAC_W = 12;
  localparam int MON_LSB = 21;
  localparam int RF_EN_POS = 6;
  localparam int LO_DIV_POS = 5;
  localparam int LO_EXT_POS = 4;
  localparam int LO_DRV_POS = 3;

  // ---------------------------------------------------------------
  // Bus map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_WORD0 = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_RATIO = 8'h24;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // Status bit positions
  localparam int ST_RF = 0;
  localparam int ST_LO_DRV = 1;
  localparam int ST_LO_DBL = 2;
  localparam int ST_LO_EXT = 3;
  localparam int ST_GATE = 4;
  localparam int ST_DIR = 5;

  // ---------------------------------------------------------------
  // Pin synchroniser slots
  // ---------------------------------------------------------------
  localparam int PIN_SCK = 0;
  localparam int PIN_SDI = 1;
  localparam int PIN_LATCH = 2;
  localparam int PIN_GATE = 3;
  localparam int PIN_DIR = 4;
  localparam int PIN_REF = 5;
  localparam int NUM_PINS = 6;

  // Monitor sources
  typedef enum logic [2:0] {
    MON_LOW = 3'b000,
    MON_LOCK = 3'b001,
    MON_REF = 3'b010,
    MON_REF_DIV2 = 3'b011,
    MON_REF_DIV4 = 3'b100,
    MON_TEMP = 3'b101,
    MON_CARRY = 3'b110,
    MON_HIGH = 3'b111
  } lop_mon_sel_t;

  // LO port setting carried as one group
  typedef struct packed {
    logic drv;
    logic dbl;
    logic ext;
  } lop_lo_cfg_t;

endpackage

// file: hdl/lop_sdm.sv
// Purpose: Two-stage error-feedback modulator for the feedback divide value
// Assumes: step is a single-cycle pulse once per feedback divider cycle
// Notes: Second stage adds a zero-mean term so the average stays put
module lop_sdm import lop_pkg::*; #(
  parameter int IW = INT_W,
  parameter int FW = FRAC_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Divide settings
  input wire logic step,
  input wire logic [IW-1:0] int_val,
  input wire logic [FW-1:0] frac,
  input wire logic [FW-1:0] modulus,
  // Result
  output logic [IW:0] ratio,
  output logic carry
);

  if (FW < 2 || FW > 16 || IW < 4 || IW > 24) begin : g_chk
    $error("lop_sdm: unsupported width");
  end

  logic [FW-1:0] acc1;
  logic [FW-1:0] acc2;
  logic c2_d;
  logic [FW:0] sum1;
  logic [FW:0] sum2;
  logic c1;
  logic c2;

  // Carry when the running sum reaches the modulus; zero modulus idles
  function automatic logic wraps(input logic [FW:0] s,
                                 input logic [FW-1:0] m);
    return (m != '0) && (s >= {1'b0, m});
  endfunction

  always_comb begin
    sum1 = {1'b0, acc1} + {1'b0, frac};
    c1 = wraps(sum1, modulus);
    sum2 = {1'b0, acc2} + {1'b0, (c1 ? FW'(sum1 - {1'b0, modulus})
                                     : sum1[FW-1:0])};
    c2 = wraps(sum2, modulus);
  end

  // ---------------------------------------------------------------
  // Accumulators
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc1 <= '0;
      acc2 <= '0;
      c2_d <= 1'b0;
      ratio <= '0;
      carry <= 1'b0;
    end else if (step) begin
      // Fraction spread over time rather than a fixed cycle R6
      acc1 <= c1 ? FW'(sum1 - {1'b0, modulus}) : sum1[FW-1:0];
      acc2 <= c2 ? FW'(sum2 - {1'b0, modulus}) : sum2[FW-1:0];
      c2_d <= c2;
      // Average of int plus frac over modulus R5
      ratio <= (IW+1)'({1'b0, int_val} + (IW+1)'(c1) + (IW+1)'(c2)
                       - (IW+1)'(c2_d));
      carry <= c1;
    end
  end

  sdm_band_a: assert property (@(posedge clk) disable iff (!nrst) // R6
    $rose(step) ##1 1'b1 |-> (ratio + (IW+1)'(1) >= {1'b0, $past(int_val)})
      && (ratio <= {1'b0, $past(int_val)} + (IW+1)'(2)))
    else $error("divide value left its band");

  // Zero modulus with no stage-two carry pending leaves the integer alone
  int_only_a: assert property (@(posedge clk) disable iff (!nrst) // R5
    step && modulus == '0 && !c2_d |=> ratio == {1'b0, $past(int_val)})
    else $error("Integer-only ratio wrong");

endmodule

// file: bench/lop_host.sv
// Purpose: Host model loading 24-bit control words over the serial pins
// Assumes: Each level held five clk cycles, above the sync minimum
// Notes: Serial clock rests low between frames
module lop_host (
  // Clock
  input wire logic clk,
  // Serial pins
  output logic serial_clock_pin,
  output logic serial_data_pin,
  output logic latch_load_strobe
);
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------
  // Frame sender
  // ---------------------------------------------------------------
  initial begin
    serial_clock_pin = 1'b0;
    serial_data_pin = 1'b0;
    latch_load_strobe = 1'b0;
  end

  task automatic hold5();
    repeat (5) @(posedge clk);
  endtask

  // MSB first, so the selector bits arrive last
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      serial_data_pin <= w[i];
      hold5();
      serial_clock_pin <= 1'b1;
      hold5();
      serial_clock_pin <= 1'b0;
    end
    // Released data line flips so a stale level is never trusted
    serial_data_pin <= ~w[0];
    latch_load_strobe <= 1'b1;
    hold5();
    latch_load_strobe <= 1'b0;
    hold5();
  endtask
endmodule

// file: bench/lo_port_and_rf_enable_control_tb_top.sv
// Purpose: Self-checking bench for the LO port and RF enable control
// Assumes: Zero-wait slave, so hready is looped from hreadyout
// Notes: Ref-derived monitor codes are checked with the reference idle
module lo_port_and_rf_enable_control_tb_top import lop_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------
  // Signals and tasks
  // ---------------------------------------------------------------
  logic clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
  logic gate = 1'b0, dir = 1'b0, refp = 1'b0, lock = 1'b0, temp = 1'b0;
  logic hreadyout, hresp, sck, sdi, latch, rf_out, mon;
  logic [31:0] hrdata;
  lop_lo_cfg_t lo_port_pair;
  logic [INT_W:0] divide_ratio;
  logic rd_pend = 1'b0;
  logic [31:0] seed = 32'h0000_004F;
  logic [31:0] exp_q[$];
  string name_q[$];
  int fail_count = 0;
  int n_compared = 0;

  always #2 clk = ~clk;

  lop_ctl uut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .serial_clock_pin(sck), .serial_data_pin(sdi),
    .latch_load_strobe(latch), .rf_out_gate_pin(gate),
    .lo_direction_pin(dir), .pll_source_clock_pin(refp),
    .lock_detect(lock), .temp_flag(temp), .modulator_output(rf_out),
    .lo_port_pair(lo_port_pair), .monitor_output_pin(mon),
    .divide_ratio(divide_ratio));

  lop_host host (.clk(clk), .serial_clock_pin(sck),
    .serial_data_pin(sdi), .latch_load_strobe(latch));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic summarize();
    if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  // Bounded wait; a hang counts as a mismatch
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      fail_count++;
      summarize();
    end
  endtask

  // For a read, d is the expected word
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d, input string nm);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rd_pend <= !w;
    if (!w) begin
      exp_q.push_back(d);
      name_q.push_back(nm);
    end
    wait_rdy();
    rd_pend <= 1'b0;
  endtask

  always @(posedge clk) begin
    if (rd_pend === 1'b1 && hreadyout === 1'b1 && exp_q.size() > 0) begin
      chk("hresp", 0, {31'h0, hresp});
      chk(name_q.pop_front(), exp_q.pop_front(), hrdata);
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [23:0] w;
    logic [5:0] c;
    logic od, oe, bad, e;
    logic [INT_W:0] prev;
    int sum, chg;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++) bus(8'(4 * i), 0, 0, "word_reset");
    bus(ADDR_STATUS, 0, 0, "status_reset");
    bus(8'h28, 1, 32'hFFFF_FFFF, "");
    bus(8'h28, 0, 0, "unmapped");
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      bus(8'(4 * i), 1, seed, "");
      bus(8'(4 * i), 0, {8'h00, seed[23:0]}, "word_rw");
    end
    // Every pin and bit mix: c = {dir, gate, rf, div, ext, drv}
    for (int i = 0; i < 64; i++) begin
      c = 6'(i);
      gate <= c[4];
      dir <= c[5];
      bus(8'h14, 1, {25'h0, c[3:0], 3'h5}, "");
      repeat (8) @(posedge clk);
      oe = !c[5] && c[1] && !c[0];
      od = !c[1] && (c[5] || c[0]);
      bus(ADDR_STATUS, 0, {26'h0, c[5:4], oe, od & c[2], od,
          c[4] & c[3]}, "status");
      chk("pins", {28'h0, c[4] & c[3], od, od & c[2], oe},
          {28'h0, rf_out, lo_port_pair});
    end
    for (int k = 7; k >= 0; k--) begin
      seed = lfsr(seed);
      w = {seed[20:0], 3'(k)};
      host.send(w);
      bus(8'(4 * k), 0, {8'h00, w}, "serial_word");
    end
    for (int m = 0; m < 8; m++) begin
      seed = lfsr(seed);
      lock <= seed[0];
      temp <= seed[1];
      bus(8'h10, 1, {8'h00, 3'(m), 21'h4}, "");
      repeat (4) @(posedge clk);
      // Reference idle and modulator unstepped, so those codes read low
      e = (m == 7) || (m == 1 && seed[0]) || (m == 5 && seed[1]);
      chk("monitor", {31'h0, e}, {31'h0, mon});
    end
    // Integer 100, fraction 1 over modulus 2
    bus(8'h00, 1, {13'h0, 16'h0064, 3'h0}, "");
    bus(8'h04, 1, 32'h0000_0009, "");
    bus(8'h08, 1, 32'h0000_0012, "");
    sum = 0;
    chg = 0;
    bad = 1'b0;
    prev = divide_ratio;
    // First 40 cycles let the ratio leave its reset value of zero
    for (int i = 0; i < 4040; i++) begin
      @(posedge clk);
      refp <= (i % 10) < 5;
      if (i >= 40) begin
        sum += int'(divide_ratio);
        bad = bad | (divide_ratio < 99) | (divide_ratio > 102);
        if (divide_ratio !== prev) chg++;
      end
      prev = divide_ratio;
    end
    chk("ratio_span", 0, {31'h0, bad});
    chk("ratio_moves", 1, {31'h0, chg > 100});
    chk("ratio_mean", 1, {31'h0, sum >= 401200 && sum <= 402800});
    bus(8'h08, 1, 32'h0000_0002, "");
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      refp <= (i % 10) < 5;
    end
    bus(ADDR_RATIO, 0, 32'h0000_0064, "ratio");
    // Host turns RF off and the LO port off with it
    dir <= 1'b0;
    host.send({17'h0_0000, 7'h05});
    bus(ADDR_STATUS, 0, 32'h0000_0010, "rf_lo_off");
    // Let the last read reach the checker before the verdict
    repeat (2) @(posedge clk);
    summarize();
  end
endmodule
